// ===== design/prot_mode_pkg.sv
/*
  shared constants for the protection mode control register block:
  frame layout, register offset, field positions, reset value and
  report waveform timing. assumes a 10 mhz system clock.
*/
package prot_mode_pkg;

  // ==========================================================
  // serial frame layout
  localparam int FRAME_BITS = 24;
  localparam int FRAME_RW_POS = 23;
  localparam int FRAME_ADDR_HI = 22;
  localparam int FRAME_ADDR_LO = 18;
  localparam int FRAME_DATA_HI = 17;
  localparam int FRAME_DATA_LO = 8;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 10;
  localparam int CRC_W = 8;
  localparam logic [ADDR_W-1:0] PROT_MODE_OFFSET = 5'h00;

  // ==========================================================
  // field positions inside the ten data bits
  localparam int F_REPORT_SEL = 9;
  localparam int F_SEG_DRIVE = 8;
  localparam int F_MILLER = 7;
  localparam int F_TIMER_UNSCALED = 6;
  localparam int F_SOFT_SHUTDOWN = 5;
  localparam int F_TWO_LEVEL = 4;
  localparam int F_ACT_CLAMP = 3;
  localparam int F_SAT_LOSS = 2;
  localparam int F_SHORT_CUR = 1;
  localparam int F_OVER_CUR = 0;
  localparam logic [DATA_W-1:0] PROT_MODE_RESET = 10'h0f4;

  // ==========================================================
  // report waveform timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TEMP_WAVE_HZ = 3900;
  localparam int SECOND_WAVE_HZ = 5600;
  localparam int PERIOD_W = 12;
  localparam logic [PERIOD_W-1:0] TEMP_PERIOD_CYC = PERIOD_W'(CLK_HZ / TEMP_WAVE_HZ);
  localparam logic [PERIOD_W-1:0] SECOND_PERIOD_CYC = PERIOD_W'(CLK_HZ / SECOND_WAVE_HZ);
  localparam int DUTY_MIN_PCT = 10;
  localparam int DUTY_MAX_PCT = 90;
  localparam int CODE_FULL = 1023;

endpackage : prot_mode_pkg

// ===== design/frame_if.sv
/*
  carrier between the serial frame port and the register core.
  assumes both ends run on the same system clock.
*/
interface frame_if;
  logic frame_done;
  logic [23:0] frame_word;
  logic [23:0] reply_word;

  modport port (output frame_done, output frame_word, input reply_word);
  modport core (input frame_done, input frame_word, output reply_word);
endinterface : frame_if

// ===== design/serial_frame_port.sv
/*
  serial frame port: oversamples chip select, serial clock and data
  in on the system clock, collects 24-bit frames msb first.
  assumes the serial clock is well below a quarter of clk_i.
*/
module serial_frame_port
  import prot_mode_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic csb_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // core side
  frame_if.port link
);

  // ==========================================================
  // synchronisers
  logic csb_s1, csb_s2, csb_s3;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic mosi_s1, mosi_s2;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [4:0] bit_cnt;

  wire sclk_rise = sclk_s2 & ~sclk_s3;
  wire sclk_fall = ~sclk_s2 & sclk_s3;
  wire csb_fall = ~csb_s2 & csb_s3;
  wire csb_rise = csb_s2 & ~csb_s3;
  // a frame with any other bit count is dropped whole
  wire frame_ok = (bit_cnt == 5'(FRAME_BITS));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {csb_s1, csb_s2, csb_s3} <= 3'h7;
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {mosi_s1, mosi_s2} <= 2'h0;
      shift_in <= '0;
      shift_out <= '0;
      bit_cnt <= '0;
      link.frame_done <= 1'b0;
      link.frame_word <= '0;
    end else begin
      {csb_s1, csb_s2, csb_s3} <= {csb_n_i, csb_s1, csb_s2};
      {sclk_s1, sclk_s2, sclk_s3} <= {sclk_i, sclk_s1, sclk_s2};
      {mosi_s1, mosi_s2} <= {mosi_i, mosi_s1};
      link.frame_done <= csb_rise & frame_ok;
      if (csb_rise && frame_ok) begin
        link.frame_word <= shift_in;
      end
      if (csb_fall) begin
        bit_cnt <= '0;
        shift_out <= link.reply_word;
      end else if (!csb_s2 && sclk_rise) begin
        shift_in <= {shift_in[FRAME_BITS-2:0], mosi_s2};
        if (bit_cnt != 5'h1f) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end else if (!csb_s2 && sclk_fall) begin
        shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  assign miso_o = shift_out[FRAME_BITS-1];
  assign miso_oe_o = ~csb_s2;

endmodule : serial_frame_port

// ===== design/analog_report_pwm.sv
/*
  analog report waveform: duty cycle 10 % to 90 % over a 10-bit code.
  assumes the codes are steady within a period; they are sampled at
  each period start so a changing code never splits a pulse.
*/
module analog_report_pwm
  import prot_mode_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control and codes
  input wire logic alternate_i,
  input wire logic [DATA_W-1:0] temp_code_i,
  input wire logic [DATA_W-1:0] second_code_i,
  // waveform
  output logic report_o
);

  function automatic logic [PERIOD_W-1:0] high_len(input logic [DATA_W-1:0] code,
                                                  input logic [PERIOD_W-1:0] period);
    int base;
    int span;
    base = (int'(period) * DUTY_MIN_PCT) / 100;
    span = (int'(code) * int'(period) * (DUTY_MAX_PCT - DUTY_MIN_PCT)) / (100 * CODE_FULL);
    return PERIOD_W'(base + span);
  endfunction : high_len

  // ==========================================================
  // period counter and phase
  logic [PERIOD_W-1:0] cnt;
  logic [PERIOD_W-1:0] high_cnt;
  logic second_phase;

  wire next_second = alternate_i & ~second_phase;
  wire [PERIOD_W-1:0] period = second_phase ? SECOND_PERIOD_CYC : TEMP_PERIOD_CYC;
  wire [PERIOD_W-1:0] next_period = next_second ? SECOND_PERIOD_CYC : TEMP_PERIOD_CYC;
  wire [DATA_W-1:0] next_code = next_second ? second_code_i : temp_code_i;
  wire period_end = (cnt == period - 12'h001);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      high_cnt <= '0;
      second_phase <= 1'b0;
      report_o <= 1'b0;
    end else begin
      if (period_end) begin
        cnt <= '0;
        second_phase <= next_second;
        high_cnt <= high_len(next_code, next_period);
      end else begin
        cnt <= cnt + 12'h001;
      end
      report_o <= (cnt < high_cnt);
    end
  end

endmodule : analog_report_pwm

// ===== design/gate_driver_protection_mode_reg.sv
/*
  protection mode control register of an isolated gate driver, its
  serial frame access and the function enables derived from it.
  assumes the configuration mode and device reset bits, the fault cause
  and the converted codes arrive from other logic on clk_i.
*/

module gate_driver_protection_mode_reg
  import prot_mode_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // serial pins
  input wire logic csb_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // mode controls from the second mode register
  input wire logic config_mode_enable_i,
  input wire logic device_reset_i,
  // shutdown cause: saturation loss or short circuit
  input wire logic cause_sat_or_short_i,
  // converted codes for the report output
  input wire logic [DATA_W-1:0] temperature_sense_input_i,
  input wire logic [DATA_W-1:0] second_quantity_i,
  // stored register value
  output logic [DATA_W-1:0] protection_mode_control_o,
  // derived function enables
  output logic analog_report_output_o,
  output logic segmented_drive_active_o,
  output logic miller_clamp_drive_o,
  output logic clamp_threshold_comparator_on_o,
  output logic timer_double_o,
  output logic soft_shutdown_apply_o,
  output logic two_level_turnoff_apply_o,
  output logic collector_active_clamp_active_o,
  output logic saturation_loss_mgmt_o,
  output logic short_current_mgmt_o,
  output logic overcurrent_mgmt_o,
  // gate and mode status
  output logic gate_hold_off_o,
  output logic switching_disable_o,
  output logic config_active_o,
  output logic fault_interrupt_force_low_o,
  output logic crc_store_o
);

  // ==========================================================
  // frame port
  frame_if link();

  serial_frame_port u_port (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .csb_n_i(csb_n_i),
    .sclk_i(sclk_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .link(link)
  );

  // ==========================================================
  // frame decode
  logic [DATA_W-1:0] protection_mode_control;
  logic [FRAME_BITS-1:0] reply;
  logic config_seen;
  logic csb_q1;
  logic csb_q2;
  logic csb_q3;

  wire frame_is_write = link.frame_word[FRAME_RW_POS];
  wire [ADDR_W-1:0] frame_addr = link.frame_word[FRAME_ADDR_HI:FRAME_ADDR_LO];
  wire [DATA_W-1:0] frame_data = link.frame_word[FRAME_DATA_HI:FRAME_DATA_LO];
  wire addr_hit = (frame_addr == PROT_MODE_OFFSET);

  // configuration is not possible while the device sits in reset
  wire config_allowed = config_mode_enable_i & ~device_reset_i;
  // writes outside configuration mode are silently dropped
  wire write_take = link.frame_done & frame_is_write & addr_hit & config_allowed;
  wire read_take = link.frame_done & ~frame_is_write & addr_hit;

  // chip select rise seen locally, for the crc store moment
  wire csb_rise = csb_q2 & ~csb_q3;

  // ==========================================================
  // register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || device_reset_i) begin
      protection_mode_control <= PROT_MODE_RESET;
    end else if (write_take) begin
      protection_mode_control <= frame_data;
    end
  end

  // ==========================================================
  // reply for the next frame
  // only this register is answered here; other addresses read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reply <= '0;
    end else if (read_take) begin
      reply <= {1'b0, PROT_MODE_OFFSET, protection_mode_control, {CRC_W{1'b0}}};
    end else if (link.frame_done) begin
      reply <= '0;
    end
  end

  assign link.reply_word = reply;

  // ==========================================================
  // crc store at the first chip select rise after leaving configuration
  // the crc itself is computed elsewhere; this only marks the moment
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {csb_q1, csb_q2, csb_q3} <= 3'h7;
    end else begin
      {csb_q1, csb_q2, csb_q3} <= {csb_n_i, csb_q1, csb_q2};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      crc_store_o <= 1'b0;
    end else begin
      crc_store_o <= csb_rise & config_seen & ~config_allowed;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      config_seen <= 1'b0;
    end else if (config_allowed) begin
      config_seen <= 1'b1;
    end else if (csb_rise || device_reset_i) begin
      config_seen <= 1'b0;
    end
  end

  // ==========================================================
  // field views
  wire report_sel = protection_mode_control[F_REPORT_SEL];
  wire seg_drive = protection_mode_control[F_SEG_DRIVE];
  wire miller_en = protection_mode_control[F_MILLER];
  wire timer_unscaled = protection_mode_control[F_TIMER_UNSCALED];
  wire ssd_en = protection_mode_control[F_SOFT_SHUTDOWN];
  wire two_level_en = protection_mode_control[F_TWO_LEVEL];
  wire act_clamp_en = protection_mode_control[F_ACT_CLAMP];
  wire sat_loss_en = protection_mode_control[F_SAT_LOSS];
  wire short_cur_en = protection_mode_control[F_SHORT_CUR];
  wire over_cur_en = protection_mode_control[F_OVER_CUR];

  // ==========================================================
  // derived enables
  wire clamp_allowed = act_clamp_en & ~seg_drive;
  wire oc_allowed = over_cur_en & ~seg_drive & ~act_clamp_en;
  // other shutdown causes always take the soft path
  wire ssd_apply = cause_sat_or_short_i ? ssd_en : 1'b1;
  wire two_level_apply = cause_sat_or_short_i & two_level_en;

  // one short register per enable, so each can be traced alone
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      segmented_drive_active_o <= 1'b0;
    end else begin
      segmented_drive_active_o <= seg_drive;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      miller_clamp_drive_o <= 1'b0;
    end else begin
      miller_clamp_drive_o <= miller_en;
    end
  end

  // the comparator never depends on the enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clamp_threshold_comparator_on_o <= 1'b0;
    end else begin
      clamp_threshold_comparator_on_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_double_o <= 1'b0;
    end else begin
      timer_double_o <= ~timer_unscaled;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      soft_shutdown_apply_o <= 1'b1;
    end else begin
      soft_shutdown_apply_o <= ssd_apply;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      two_level_turnoff_apply_o <= 1'b0;
    end else begin
      two_level_turnoff_apply_o <= two_level_apply;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      collector_active_clamp_active_o <= 1'b0;
    end else begin
      collector_active_clamp_active_o <= clamp_allowed;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      saturation_loss_mgmt_o <= 1'b0;
    end else begin
      saturation_loss_mgmt_o <= sat_loss_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      short_current_mgmt_o <= 1'b0;
    end else begin
      short_current_mgmt_o <= short_cur_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      overcurrent_mgmt_o <= 1'b0;
    end else begin
      overcurrent_mgmt_o <= oc_allowed;
    end
  end

  // ==========================================================
  // gate and mode status
  wire hold_request = config_mode_enable_i | device_reset_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gate_hold_off_o <= 1'b1;
    end else begin
      gate_hold_off_o <= hold_request;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      switching_disable_o <= 1'b1;
    end else begin
      switching_disable_o <= hold_request;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      config_active_o <= 1'b0;
    end else begin
      config_active_o <= config_allowed;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_interrupt_force_low_o <= 1'b0;
    end else begin
      fault_interrupt_force_low_o <= device_reset_i;
    end
  end

  assign protection_mode_control_o = protection_mode_control;

  // ==========================================================
  // report waveform
  analog_report_pwm u_report (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .alternate_i(report_sel),
    .temp_code_i(temperature_sense_input_i),
    .second_code_i(second_quantity_i),
    .report_o(analog_report_output_o)
  );

endmodule : gate_driver_protection_mode_reg

// ===== verif/prot_mode_sva.sv
/* port assertions for the protection mode register block.
   assumes one clock domain and the bind at the foot of this file. */
module prot_mode_sva
  import prot_mode_pkg::*;
(
  // clock, reset and inputs
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic csb_n_i,
  input wire logic config_mode_enable_i,
  input wire logic device_reset_i,
  input wire logic cause_sat_or_short_i,
  // outputs
  input wire logic miso_oe_o,
  input wire logic [DATA_W-1:0] protection_mode_control_o,
  input wire logic miller_clamp_drive_o,
  input wire logic clamp_threshold_comparator_on_o,
  input wire logic timer_double_o,
  input wire logic soft_shutdown_apply_o,
  input wire logic two_level_turnoff_apply_o,
  input wire logic collector_active_clamp_active_o,
  input wire logic saturation_loss_mgmt_o,
  input wire logic short_current_mgmt_o,
  input wire logic overcurrent_mgmt_o,
  input wire logic gate_hold_off_o,
  input wire logic fault_interrupt_force_low_o,
  input wire logic crc_store_o
);
  // ========================================
  // helpers
  // outputs lag one clock, so the first edge after reset is skipped
  logic was_rst;
  wire logic [DATA_W-1:0] v = protection_mode_control_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge clk_i) was_rst <= sys_rst_i;
  // ========================================
  // assertions
  miller_follow_a: assert property (!was_rst |->
    miller_clamp_drive_o == $past(v[7]) && clamp_threshold_comparator_on_o)
    else $error("miller clamp drive mismatch");
  timer_scale_a: assert property (!was_rst |-> timer_double_o == !$past(v[6]))
    else $error("timer doubling mismatch");
  soft_off_a: assert property (!was_rst |->
    soft_shutdown_apply_o == ($past(cause_sat_or_short_i) ? $past(v[5]) : 1'b1))
    else $error("soft shutdown mismatch");
  two_level_a: assert property (!was_rst |->
    two_level_turnoff_apply_o == ($past(v[4]) && $past(cause_sat_or_short_i)))
    else $error("two level turn-off mismatch");
  clamp_gate_a: assert property (!was_rst |->
    collector_active_clamp_active_o == ($past(v[3]) && !$past(v[8])))
    else $error("active clamp mismatch");
  fault_mgmt_a: assert property (!was_rst |->
    {saturation_loss_mgmt_o, short_current_mgmt_o} == $past(v[2:1]))
    else $error("fault management mismatch");
  over_gate_a: assert property (!was_rst |->
    overcurrent_mgmt_o == ($past(v[0]) && !$past(v[8]) && !$past(v[3])))
    else $error("overcurrent management mismatch");
  write_lock_a: assert property ($changed(v) |->
    $past(config_mode_enable_i) || $past(config_mode_enable_i, 2) || $past(device_reset_i))
    else $error("register changed while locked");
  hold_off_a: assert property (!was_rst |->
    gate_hold_off_o == ($past(config_mode_enable_i) || $past(device_reset_i)))
    else $error("gate hold off mismatch");
  crc_pulse_a: assert property (crc_store_o |-> !config_mode_enable_i ##1 !crc_store_o)
    else $error("crc store pulse wrong");
  dev_reset_a: assert property (device_reset_i |=>
    v == 10'h0f4 && fault_interrupt_force_low_o && gate_hold_off_o)
    else $error("device reset not applied");
  idle_out_a: assert property (csb_n_i [*5] |-> !miso_oe_o)
    else $error("serial out driven while deselected");
  cover property (crc_store_o);
  cover property (device_reset_i ##1 fault_interrupt_force_low_o);
  cover property (overcurrent_mgmt_o);
endmodule : prot_mode_sva

bind gate_driver_protection_mode_reg prot_mode_sva u_prot_mode_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .csb_n_i(csb_n_i), .miso_oe_o(miso_oe_o),
  .config_mode_enable_i(config_mode_enable_i), .device_reset_i(device_reset_i),
  .cause_sat_or_short_i(cause_sat_or_short_i),
  .protection_mode_control_o(protection_mode_control_o),
  .miller_clamp_drive_o(miller_clamp_drive_o),
  .clamp_threshold_comparator_on_o(clamp_threshold_comparator_on_o),
  .timer_double_o(timer_double_o), .soft_shutdown_apply_o(soft_shutdown_apply_o),
  .two_level_turnoff_apply_o(two_level_turnoff_apply_o),
  .collector_active_clamp_active_o(collector_active_clamp_active_o),
  .saturation_loss_mgmt_o(saturation_loss_mgmt_o), .short_current_mgmt_o(short_current_mgmt_o),
  .overcurrent_mgmt_o(overcurrent_mgmt_o), .gate_hold_off_o(gate_hold_off_o),
  .fault_interrupt_force_low_o(fault_interrupt_force_low_o), .crc_store_o(crc_store_o));

// ===== verif/spi_host_model.sv
/* host side of the serial link: sends 24-bit frames msb first, gathers the reply.
   assumes the device takes data on the rising serial clock. */
module spi_host_model (
  // clock
  input wire logic clk_i,
  // pins
  output logic csb_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    csb_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b1;
  end
  // ========================================
  // frame transfer
  // five clocks per half period keeps clear of the four-clock minimum
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_i);
      csb_n_o <= 1'b0;
      sclk_o <= 1'b0;
      mosi_o <= w[i];
      repeat (5) @(posedge clk_i);
      r[i] = miso_i;
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    mosi_o <= ~w[0];
    repeat (5) @(posedge clk_i);
    csb_n_o <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask : xfer
endmodule : spi_host_model

// ===== verif/gate_driver_protection_mode_reg_tb_top.sv
/* self-checking bench for the protection mode register block.
   assumes the host model and the bound checker alongside. */
module gate_driver_protection_mode_reg_tb_top
  import prot_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================
  // signals
  logic clk_i, sys_rst_i, config_i, dev_rst, cause;
  logic [DATA_W-1:0] temp, sec;
  logic [23:0] r;
  wire logic csb_n, sclk, mosi, miso, rep, gate, sw_off, cfg_act, int_low, crc;
  wire logic [DATA_W-1:0] rg;
  wire logic [8:0] flags;
  int n_fail = 0, checked = 0, n_crc = 0;
  logic [9:0] vals [5] = '{10'h3ff, 10'h001, 10'h10b, 10'h0a9, 10'h2f4};
  logic [9:0] codes [2] = '{10'h000, 10'h3ff};
  gate_driver_protection_mode_reg u_gate_driver_protection_mode_reg (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .csb_n_i(csb_n), .sclk_i(sclk), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(), .config_mode_enable_i(config_i), .device_reset_i(dev_rst),
    .cause_sat_or_short_i(cause), .temperature_sense_input_i(temp), .second_quantity_i(sec),
    .protection_mode_control_o(rg), .analog_report_output_o(rep),
    .segmented_drive_active_o(flags[8]), .miller_clamp_drive_o(flags[7]),
    .clamp_threshold_comparator_on_o(), .timer_double_o(flags[6]),
    .soft_shutdown_apply_o(flags[5]), .two_level_turnoff_apply_o(flags[4]),
    .collector_active_clamp_active_o(flags[3]), .saturation_loss_mgmt_o(flags[2]),
    .short_current_mgmt_o(flags[1]), .overcurrent_mgmt_o(flags[0]),
    .gate_hold_off_o(gate), .switching_disable_o(sw_off), .config_active_o(cfg_act),
    .fault_interrupt_force_low_o(int_low), .crc_store_o(crc));
  spi_host_model u_spi_host_model (
    .clk_i(clk_i), .csb_n_o(csb_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) n_crc += (crc === 1'b1);
  // ========================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    u_spi_host_model.xfer({1'b1, a, d, 8'h00}, r);
  endtask : wr
  function automatic logic [8:0] want(input logic [9:0] v, input logic c);
    return {v[8], v[7], ~v[6], c ? v[5] : 1'b1, v[4] & c, v[3] & ~v[8], v[2], v[1],
      v[0] & ~v[8] & ~v[3]};
  endfunction : want
  function automatic int duty(input int code, input int per);
    return per * 10 / 100 + code * per * 80 / (100 * 1023);
  endfunction : duty
  task automatic report_and_stop();
    $display("checks %0d, failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // one period from rising edge to rising edge, bounded
  // without sync it starts on the rise at which the previous call stopped
  task automatic measure(input bit sync, output int h, output int p);
    h = 0;
    p = 0;
    for (int k = 0; k < 6000 && sync && rep !== 1'b0; k++) tick(1);
    for (int k = 0; k < 6000 && sync && rep !== 1'b1; k++) tick(1);
    do begin
      h += (rep === 1'b1);
      p++;
      tick(1);
    end while (p < 6000 && !(rep === 1'b1 && h < p));
    if (p == 6000) begin
      check(24'h0, 24'h1);
      report_and_stop();
    end
  endtask : measure
  // ========================================
  // tests
  initial begin
    int h1, p1, h2, p2;
    sys_rst_i = 1'b1;
    config_i = 1'b0;
    dev_rst = 1'b0;
    cause = 1'b0;
    temp = 10'h000;
    sec = 10'h000;
    tick(5);
    sys_rst_i <= 1'b0;
    tick(4);
    check(rg, 10'h0f4);
    check(flags, want(10'h0f4, 1'b0));
    $display("test 1 done");
    config_i <= 1'b1;
    tick(3);
    check({gate, sw_off, cfg_act}, 3'b111);
    foreach (vals[i]) begin
      wr(5'h00, vals[i]);
      check(rg, vals[i]);
      for (int c = 0; c < 2; c++) begin
        cause <= c[0];
        tick(3);
        check(flags, want(vals[i], c[0]));
      end
    end
    wr(5'h01, 10'h155);
    check(rg, 10'h2f4);
    u_spi_host_model.xfer(24'h000000, r);
    u_spi_host_model.xfer(24'h040000, r);
    check(r, 24'h02f400);
    $display("test 2 done");
    config_i <= 1'b0;
    tick(3);
    n_crc = 0;
    wr(5'h00, 10'h000);
    check(24'(n_crc), 24'd1);
    check(rg, 10'h2f4);
    $display("test 3 done");
    temp <= 10'h3ff;
    sec <= 10'h200;
    measure(1'b1, h1, p1);
    measure(1'b0, h2, p2);
    check(24'(p1 + p2), 24'd4349);
    check(24'(h1), 24'(duty(p1 == 2564 ? 1023 : 512, p1)));
    $display("test 4 done");
    config_i <= 1'b1;
    wr(5'h00, 10'h0f4);
    config_i <= 1'b0;
    foreach (codes[i]) begin
      temp <= codes[i];
      measure(1'b1, h1, p1);
      measure(1'b0, h2, p2);
      check({12'(p1), 12'(p2)}, {12'd2564, 12'd2564});
      check(24'(h2), 24'(duty(codes[i], 2564)));
    end
    $display("test 5 done");
    config_i <= 1'b1;
    wr(5'h00, 10'h3ff);
    dev_rst <= 1'b1;
    tick(2);
    check({rg, gate, sw_off, cfg_act, int_low}, {10'h0f4, 4'b1101});
    wr(5'h00, 10'h000);
    check(rg, 10'h0f4);
    dev_rst <= 1'b0;
    config_i <= 1'b0;
    tick(3);
    $display("test 6 done");
    report_and_stop();
  end
endmodule : gate_driver_protection_mode_reg_tb_top
